// File: verilog/tsrs_regs.svh
// Register map constants for the timestamp record store
// Functional notes
// - The hour format bit chooses a 24-hour count 0-23 when clear and a 12-hour count 1-12 when set.
// - In 12-hour format hour bit 5 is the meridiem marker, zero for morning and one for afternoon.
// - In 24-hour format hour bit 5 instead holds the BCD twenty-hours digit.
// - Hour bit 4 holds the ten-hours digit and bits 3:0 the units-of-hours digit.
// - Seconds keep the tens digit in bits 6:4 and the units digit in bits 3:0, bit 7 unused.
// - Flag bit 3 is set when the capture came from a low-battery detection and reads zero otherwise.
// - Flag bits 2, 1, 0 mark captures from main-to-backup switch, backup-to-main switch, event pin.
`ifndef TSRS_REGS_SVH
`define TSRS_REGS_SVH
`define TSRS_OFS_SECONDS   8'h21
`define TSRS_OFS_MINUTES   8'h22
`define TSRS_OFS_HOURS     8'h23
`define TSRS_OFS_DAY       8'h24
`define TSRS_OFS_MONTH     8'h25
`define TSRS_OFS_YEARS     8'h26
`define TSRS_OFS_FLAGS     8'h27
`define TSRS_RESET_VAL     8'h00
`define TSRS_MASK_SECONDS  8'h7F
`define TSRS_MASK_MINUTES  8'h7F
`define TSRS_MASK_HOURS    8'h7F
`define TSRS_MASK_DAY      8'h3F
`define TSRS_MASK_MONTH    8'h9F
`define TSRS_MASK_YEARS    8'hFF
`define TSRS_MASK_FLAGS    8'h0F
`define TSRS_HR_FMT_BIT    6
`define TSRS_HR_B5_BIT     5
`define TSRS_HR_TENS_BIT   4
`define TSRS_FLAG_LOWBAT   3
`define TSRS_FLAG_TOBKP    2
`define TSRS_FLAG_TOMAIN   1
`define TSRS_FLAG_EVENT    0
`endif

// File: verilog/tsrs_pkg.sv
// Types for the timestamp record store
package tsrs_pkg;
   typedef enum logic [2:0] {
      TSRS_SEL_SECONDS,
      TSRS_SEL_MINUTES,
      TSRS_SEL_HOURS,
      TSRS_SEL_DAY,
      TSRS_SEL_MONTH,
      TSRS_SEL_YEARS,
      TSRS_SEL_FLAGS,
      TSRS_SEL_NONE
   } tsrs_sel_t;

   typedef struct packed {
      logic [2:0] s_tens_digit;
      logic [3:0] s_units_digit;
      logic [6:0] minutes;
      logic       hour_12_fmt;
      logic       meridiem_or_h_twenties;
      logic       h_tens_bit;
      logic [3:0] h_units;
      logic [5:0] day;
      logic       hundred_yr_bit;
      logic [4:0] month;
      logic [7:0] years;
   } tsrs_time_t;

   typedef struct packed {
      logic low_battery_trigger_flag;
      logic to_backup_trigger_flag;
      logic to_main_trigger_flag;
      logic event_pin_trigger_flag;
   } tsrs_flags_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } tsrs_req_t;
endpackage

// File: verilog/tsrs_decode.sv
// Address decoder for the timestamp record store
`timescale 1ns/1ns
`include "tsrs_regs.svh"
module tsrs_decode
   import tsrs_pkg::*;
(
   input  wire logic [7:0] addr,
   output tsrs_sel_t       sel
);
   always_comb begin
      case (addr)
         `TSRS_OFS_SECONDS: sel = TSRS_SEL_SECONDS;
         `TSRS_OFS_MINUTES: sel = TSRS_SEL_MINUTES;
         `TSRS_OFS_HOURS:   sel = TSRS_SEL_HOURS;
         `TSRS_OFS_DAY:     sel = TSRS_SEL_DAY;
         `TSRS_OFS_MONTH:   sel = TSRS_SEL_MONTH;
         `TSRS_OFS_YEARS:   sel = TSRS_SEL_YEARS;
         `TSRS_OFS_FLAGS:   sel = TSRS_SEL_FLAGS;
         default:           sel = TSRS_SEL_NONE;
      endcase
   end
endmodule

// File: verilog/tsrs_store.sv
// Timestamp record store: captured time, date and trigger flags
`timescale 1ns/1ns
`include "tsrs_regs.svh"
module tsrs_store
   import tsrs_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  tsrs_req_t        req,
   output logic [7:0]       rdata,
   output logic             rvalid,
   input  wire logic        capture,
   input  tsrs_time_t       cap_time,
   input  tsrs_flags_t      cap_flags,
   output tsrs_time_t       rec_time,
   output tsrs_flags_t      rec_flags,
   output logic             is_12h,
   output logic             is_pm,
   output logic [5:0]       hours_24
);
   tsrs_sel_t   sel;
   tsrs_time_t  time_q;
   tsrs_flags_t flags_q;
   logic [7:0]  rd_d;

   tsrs_decode tsrs_decode_inst (
      .addr (req.addr),
      .sel  (sel)
   );

   // Masked read-back of one stored byte
   function automatic logic [7:0] wmask(input logic [7:0] v, input logic [7:0] m);
      wmask = v & m;
   endfunction

   // Record contents: capture wins over a software write
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         time_q  <= '0;
         flags_q <= '0;
      end else if (capture) begin
         time_q  <= cap_time;
         flags_q <= cap_flags;
      end else if (req.wr) begin
         case (sel)
            TSRS_SEL_SECONDS: begin
               time_q.s_tens_digit  <= req.wdata[6:4];
               time_q.s_units_digit <= req.wdata[3:0];
            end
            TSRS_SEL_MINUTES: time_q.minutes <= req.wdata[6:0];
            TSRS_SEL_HOURS: begin
               time_q.hour_12_fmt            <= req.wdata[`TSRS_HR_FMT_BIT];
               time_q.meridiem_or_h_twenties <= req.wdata[`TSRS_HR_B5_BIT];
               time_q.h_tens_bit             <= req.wdata[`TSRS_HR_TENS_BIT];
               time_q.h_units                <= req.wdata[3:0];
            end
            TSRS_SEL_DAY:   time_q.day <= req.wdata[5:0];
            TSRS_SEL_MONTH: begin
               time_q.hundred_yr_bit <= req.wdata[7];
               time_q.month          <= req.wdata[4:0];
            end
            TSRS_SEL_YEARS: time_q.years <= req.wdata;
            TSRS_SEL_FLAGS: flags_q <= req.wdata[3:0];
            default: ;
         endcase
      end
   end

   // Read mux; reserved bits read zero
   always_comb begin
      case (sel)
         TSRS_SEL_SECONDS: rd_d = wmask({1'b0, time_q.s_tens_digit, time_q.s_units_digit},
                                        `TSRS_MASK_SECONDS);
         TSRS_SEL_MINUTES: rd_d = wmask({1'b0, time_q.minutes}, `TSRS_MASK_MINUTES);
         TSRS_SEL_HOURS:   rd_d = wmask({1'b0, time_q.hour_12_fmt,
                                         time_q.meridiem_or_h_twenties,
                                         time_q.h_tens_bit, time_q.h_units},
                                        `TSRS_MASK_HOURS);
         TSRS_SEL_DAY:     rd_d = wmask({2'b00, time_q.day}, `TSRS_MASK_DAY);
         TSRS_SEL_MONTH:   rd_d = wmask({time_q.hundred_yr_bit, 2'b00, time_q.month},
                                        `TSRS_MASK_MONTH);
         TSRS_SEL_YEARS:   rd_d = wmask(time_q.years, `TSRS_MASK_YEARS);
         TSRS_SEL_FLAGS:   rd_d = wmask({4'h0, flags_q}, `TSRS_MASK_FLAGS);
         default:          rd_d = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata  <= 8'h00;
         rvalid <= 1'b0;
      end else begin
         rvalid <= req.rd;
         if (req.rd) begin
            rdata <= rd_d;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rec_time  <= '0;
         rec_flags <= '0;
      end else begin
         rec_time  <= time_q;
         rec_flags <= flags_q;
      end
   end

   // Hour interpretation by format
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         is_12h   <= 1'b0;
         is_pm    <= 1'b0;
         hours_24 <= 6'h00;
      end else begin
         is_12h <= time_q.hour_12_fmt;
         is_pm  <= time_q.hour_12_fmt & time_q.meridiem_or_h_twenties;
         if (time_q.hour_12_fmt) begin
            hours_24 <= {1'b0, time_q.h_tens_bit, time_q.h_units};
         end else begin
            hours_24 <= {time_q.meridiem_or_h_twenties, time_q.h_tens_bit, time_q.h_units};
         end
      end
   end
endmodule

// File: testbench/tsrs_store_asserts.sv
// Port checker for the timestamp record store
`timescale 1ns/1ns
module tsrs_store_asserts
   import tsrs_pkg::*;
(
   input wire logic   core_clk,
   input wire logic   rst_n,
   input tsrs_req_t   req,
   input logic [7:0]  rdata,
   input logic        rvalid,
   input wire logic   capture,
   input tsrs_time_t  cap_time,
   input tsrs_flags_t cap_flags,
   input tsrs_time_t  rec_time,
   input tsrs_flags_t rec_flags,
   input logic        is_12h,
   input logic        is_pm,
   input logic [5:0]  hours_24
);
   tsrs_time_t r;
   assign r = rec_time;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence s_rd(logic [7:0] a);
      req.rd && req.addr == a;
   endsequence
   a_fmt_select: assert property (is_12h == r.hour_12_fmt)
      else $error("format flag differs from record");
   a_pm_marker: assert property (is_pm == (r.hour_12_fmt & r.meridiem_or_h_twenties))
      else $error("meridiem flag wrong");
   a_h24_twenties: assert property (!r.hour_12_fmt |->
      hours_24 == {r.meridiem_or_h_twenties, r.h_tens_bit, r.h_units}) else $error("24h hours wrong");
   a_h12_digits: assert property (r.hour_12_fmt |->
      hours_24 == {1'b0, r.h_tens_bit, r.h_units}) else $error("12h hours wrong");
   a_sec_top: assert property (s_rd(8'h21) |=> rvalid && !rdata[7])
      else $error("seconds read wrong");
   a_flag_top: assert property (s_rd(8'h27) |=> rvalid && rdata[7:4] == 4'h0)
      else $error("flag read upper bits set");
   a_flag_load: assert property (capture |=> ##1 rec_flags == $past(cap_flags, 2))
      else $error("flags not captured");
   a_whole_load: assert property (capture |=> ##1 rec_time == $past(cap_time, 2))
      else $error("record not captured whole");
endmodule

// File: testbench/tsrs_host.sv
// Host model issuing single-byte register accesses
`timescale 1ns/1ns
module tsrs_host
   import tsrs_pkg::*;
(
   input wire logic  core_clk,
   input logic [7:0] rdata,
   input logic       rvalid,
   output tsrs_req_t req
);
   initial req = '0;
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk) #1 req = '{1'b1, 1'b0, a, d};
      @(posedge core_clk) #1 req = '0;
   endtask
   // Read data holds until the next read; a missing valid pulse returns unknown
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk) #1 req = '{1'b0, 1'b1, a, 8'h00};
      @(posedge core_clk) #1 req = '0;
      d = rvalid ? rdata : 8'hxx;
   endtask
endmodule

// File: testbench/timestamp_record_store_bench.sv
// Self-checking bench for the timestamp record store
`timescale 1ns/1ns
module timestamp_record_store_bench;
   import tsrs_pkg::*;
   logic        core_clk = 0;
   logic        rst_n = 0;
   logic        capture = 0;
   tsrs_time_t  cap_time = '0;
   tsrs_flags_t cap_flags = '0;
   tsrs_req_t   req;
   tsrs_time_t  rec_time;
   tsrs_flags_t rec_flags;
   logic [7:0]  rdata, v;
   logic        rvalid, is_12h, is_pm;
   logic [5:0]  hours_24;
   int          mismatches = 0, n_tests = 0;
   logic [7:0]  msk [7] = '{8'h7F, 8'h7F, 8'h7F, 8'h3F, 8'h9F, 8'hFF, 8'h0F};
   logic [7:0]  ex [6] = '{8'h59, 8'h47, 8'h71, 8'h31, 8'h92, 8'h99};
   logic [7:0]  hr [2] = '{8'h23, 8'h52};
   logic [7:0]  hx [2] = '{8'h23, 8'h12};
   always #20 core_clk = ~core_clk;
   tsrs_store tsrs_store_inst (.*);
   tsrs_host tsrs_host_inst (.*);
   task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] s);
      n_tests++;
      if (s !== e) begin
         mismatches++;
         $display("CHECK FAILED %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic chk(input logic [7:0] a, input logic [7:0] e);
      tsrs_host_inst.rd(a, v);
      cmp($sformatf("reg %h", a), e, v);
   endtask
   task automatic cap();
      @(posedge core_clk) #1 capture = 1;
      @(posedge core_clk) #1 capture = 0;
   endtask
   task automatic t_masks();
      for (int i = 0; i < 7; i++) begin
         chk(8'(8'h21 + i), 8'h00);
         tsrs_host_inst.wr(8'(8'h21 + i), 8'hFF);
         chk(8'(8'h21 + i), msk[i]);
      end
      tsrs_host_inst.wr(8'h28, 8'hFF);
      chk(8'h28, 8'h00);
   endtask
   task automatic t_capture();
      cap_time = {3'h5, 4'h9, 7'h47, 3'b111, 4'h1, 6'h31, 1'b1, 5'h12, 8'h99};
      for (int i = 0; i < 4; i++) begin
         cap_flags = tsrs_flags_t'(4'h1 << i);
         cap();
         chk(8'h27, 8'h01 << i);
         for (int j = 0; j < 6; j++) chk(8'(8'h21 + j), ex[j]);
      end
      cmp("pm", 8'h01, {7'h00, is_pm});
      cmp("h24", 8'h11, {2'h0, hours_24});
   endtask
   task automatic t_hours();
      for (int i = 0; i < 2; i++) begin
         tsrs_host_inst.wr(8'h23, hr[i]);
         chk(8'h23, hr[i]);
         cmp("fmt", {7'h00, hr[i][6]}, {7'h00, is_12h});
         cmp("pm", 8'h00, {7'h00, is_pm});
         cmp("h24", hx[i], {2'h0, hours_24});
      end
   endtask
   task automatic t_collide();
      fork
         tsrs_host_inst.wr(8'h21, 8'h00);
         cap();
      join
      chk(8'h21, 8'h59);
   endtask
   task automatic end_of_test();
      if (mismatches == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge core_clk);
      #1 rst_n = 1;
      t_masks();
      t_capture();
      t_hours();
      t_collide();
      end_of_test();
   end
endmodule
bind tsrs_store tsrs_store_asserts tsrs_store_asserts_inst (.*);
